// ### verilog/hub_device.sv
// device end: register port, queues, fractional baud generator, serial shifters
`timescale 1ns/1ns
`include "hub_defines.svh"
module hub_device
    import hub_pkg::*;
#(
    parameter int DEPTH = `HUB_QUEUE_DEPTH
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    hub_link_if.dev         link,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [7:0]      rdata_o,
    input  wire logic       aux_serial_tx_i,
    output logic            aux_serial_rx_o,
    input  wire logic [3:0] aux_pin_i,
    output logic [3:0]      aux_pin_o
);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] RTS_LEVEL = CW'(DEPTH - `HUB_RTS_MARGIN);

    if (DEPTH <= `HUB_RTS_MARGIN) begin : g_chk
        $error("hub_device: queue depth too small for flow control");
    end

    localparam hub_dev_t DEV_RST = '{
        div:      `HUB_DIV_RESET,
        stuff:    `HUB_STUFF_RESET,
        boot:     1'b1,
        route:    2'b00,
        ovr:      1'b0,
        ferr:     1'b0,
        rdata:    8'h00,
        tx:       '{HUB_IDLE, 4'h0, 12'h000, 1'b0, 8'h00},
        rx:       '{HUB_IDLE, 4'h0, 12'h000, 1'b0, 8'h00},
        tx_line:  1'b1,
        rts_n:    1'b0,
        cts_s:    2'b11,
        rx_s:     2'b11,
        aux_s:    8'hFF,
        aux_pins: 4'hF,
        aux_rx:   1'b1
    };

    hub_dev_t          s;
    hub_dev_t          n;
    logic [7:0]        txf_data;
    logic              txf_valid;
    logic              txf_in_ready;
    logic              tx_pop;
    logic [7:0]        rxf_data;
    logic              rxf_valid;
    logic              rxf_in_ready;
    logic              rx_push;
    logic              rx_pop;
    logic              tx_push;
    logic [CW-1:0]     rxf_count;
    logic [CW-1:0]     txf_count;
    logic [11:0]       h0;
    logic [11:0]       h1;
    logic [11:0]       tx_lim;
    logic [11:0]       rx_lim;
    logic [3:0]        tx_next_idx;
    logic              rx_line;

    // half-bit length in reference clock cycles, any divisor 1..256
    function automatic logic [11:0] half_len(input logic [7:0] dv, input logic [3:0] nib, input logic bt);
        logic [8:0] d;
        logic [3:0] k;
        d = `HUB_DIV_BASE - {1'b0, dv};
        if (bt && d < `HUB_BOOT_MIN_DIV) begin
            d = `HUB_BOOT_MIN_DIV;
        end
        k = (nib > `HUB_STUFF_MAX) ? `HUB_STUFF_MAX : nib;
        half_len = {d, 3'b000} + {8'h00, k};
    endfunction

    assign tx_push = wr_i && (addr_i == `HUB_ADDR_DATA);
    assign rx_pop  = rd_i && (addr_i == `HUB_ADDR_DATA);

    // transmit queue filled by software, drained by the shifter
    hub_fifo #(.W(8), .D(DEPTH)) u_txq (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (wdata_i),
        .in_valid_i  (tx_push),
        .in_ready_o  (txf_in_ready),
        .out_data_o  (txf_data),
        .out_valid_o (txf_valid),
        .out_ready_i (tx_pop),
        .count_o     (txf_count)
    );

    // receive queue filled by the shifter, drained by data reads
    hub_fifo #(.W(8), .D(DEPTH)) u_rxq (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (n.rx.sh),
        .in_valid_i  (rx_push),
        .in_ready_o  (rxf_in_ready),
        .out_data_o  (rxf_data),
        .out_valid_o (rxf_valid),
        .out_ready_i (rx_pop),
        .count_o     (rxf_count)
    );

    // next-state of the whole device
    always_comb begin
        n           = s;
        tx_pop      = 1'b0;
        rx_push     = 1'b0;
        tx_next_idx = s.tx.idx + 4'h1;
        rx_line     = s.rx_s[1];
        // both halves recomputed every cycle, so a rewrite takes effect at once
        h0 = half_len(s.div, s.stuff[7:4], s.boot);
        h1 = half_len(s.div, s.stuff[3:0], s.boot);
        tx_lim = s.tx.ph ? h1 : h0;
        rx_lim = s.rx.ph ? h1 : h0;

        // pin synchronisers
        n.cts_s = {s.cts_s[0], link.host_rts_n};
        n.rx_s  = {s.rx_s[0], link.host_tx};
        n.aux_s = {s.aux_s[0], aux_pin_i};

        // register writes: divisor, stuffing and control loaded from the register port
        n.rdata = 8'h00;
        if (wr_i) begin
            case (addr_i)
                `HUB_ADDR_DIV:   n.div   = wdata_i;
                `HUB_ADDR_STUFF: n.stuff = wdata_i;
                `HUB_ADDR_CTRL: begin
                    n.boot  = wdata_i[`HUB_CTRL_BOOT];
                    n.route = wdata_i[`HUB_CTRL_ROUTE_LO +: 2];
                end
                default: ;
            endcase
        end

        // register reads, answered in the following cycle
        if (rd_i) begin
            case (addr_i)
                `HUB_ADDR_DIV:   n.rdata = s.div;
                `HUB_ADDR_STUFF: n.rdata = s.stuff;
                `HUB_ADDR_CTRL:  n.rdata = {5'h00, s.route, s.boot};
                `HUB_ADDR_STATUS: begin
                    n.rdata = 8'h00;
                    n.rdata[`HUB_ST_TX_EMPTY]  = (txf_count == '0) && (s.tx.st == HUB_IDLE);
                    n.rdata[`HUB_ST_RX_AVAIL]  = rxf_valid;
                    n.rdata[`HUB_ST_TX_FULL]   = !txf_in_ready;
                    n.rdata[`HUB_ST_OVERRUN]   = s.ovr;
                    n.rdata[`HUB_ST_FRAME_ERR] = s.ferr;
                    n.ovr  = 1'b0;
                    n.ferr = 1'b0;
                end
                `HUB_ADDR_DATA:  n.rdata = rxf_valid ? rxf_data : 8'h00;
                default:         n.rdata = 8'h00;
            endcase
        end

        // transmit shifter: start, eight data bits lsb first, stop
        case (s.tx.st)
            HUB_IDLE: begin
                n.tx_line = 1'b1;
                if (txf_valid && !s.cts_s[1]) begin
                    tx_pop    = 1'b1;
                    n.tx      = '{HUB_BUSY, 4'h0, 12'h000, 1'b0, txf_data};
                    n.tx_line = 1'b0;
                end
            end
            HUB_BUSY: begin
                if (s.tx.cnt == tx_lim - 12'h001) begin
                    n.tx.cnt = 12'h000;
                    n.tx.ph  = ~s.tx.ph;
                    if (s.tx.ph) begin
                        if (s.tx.idx == `HUB_LAST_BIT) begin
                            n.tx.st = HUB_IDLE;
                        end else begin
                            n.tx.idx = tx_next_idx;
                            if (s.tx.idx == 4'h0) begin
                                n.tx_line = s.tx.sh[0];
                            end else begin
                                n.tx.sh   = {1'b0, s.tx.sh[7:1]};
                                n.tx_line = (tx_next_idx == `HUB_LAST_BIT) ? 1'b1 : s.tx.sh[1];
                            end
                        end
                    end
                end else begin
                    n.tx.cnt = s.tx.cnt + 12'h001;
                end
            end
            default: n.tx.st = HUB_IDLE;
        endcase

        // receive shifter samples mid-bit, leaving margin for rate error
        case (s.rx.st)
            HUB_IDLE: begin
                if (!rx_line) begin
                    n.rx = '{HUB_BUSY, 4'h0, 12'h000, 1'b0, s.rx.sh};
                end
            end
            HUB_BUSY: begin
                if (s.rx.cnt == rx_lim - 12'h001) begin
                    n.rx.cnt = 12'h000;
                    n.rx.ph  = ~s.rx.ph;
                    if (!s.rx.ph) begin
                        n.rx.idx = s.rx.idx + 4'h1;
                        if (s.rx.idx == 4'h0) begin
                            // a glitch shorter than half a bit is no start bit
                            if (rx_line) begin
                                n.rx.st = HUB_IDLE;
                            end
                        end else if (s.rx.idx != `HUB_LAST_BIT) begin
                            n.rx.sh = {rx_line, s.rx.sh[7:1]};
                        end else begin
                            n.rx.st = HUB_IDLE;
                            if (rx_line) begin
                                rx_push = 1'b1;
                            end else begin
                                n.ferr = 1'b1;
                            end
                        end
                    end
                end else begin
                    n.rx.cnt = s.rx.cnt + 12'h001;
                end
            end
            default: n.rx.st = HUB_IDLE;
        endcase

        // lost byte: the set lands after the status-read clear, so it wins
        if (rx_push && !rxf_in_ready) begin
            n.ovr = 1'b1;
        end

        // stop the host before the queue overflows
        n.rts_n = (rxf_count >= RTS_LEVEL);

        // peripheral port: unselected pads idle high
        n.aux_pins          = 4'hF;
        n.aux_pins[s.route] = aux_serial_tx_i;
        n.aux_rx            = s.aux_s[1][s.route];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= DEV_RST;
        end else begin
            s <= n;
        end
    end

    // link pins and user outputs come straight from state
    assign link.dev_tx    = s.tx_line;
    assign link.dev_rts_n = s.rts_n;
    assign rdata_o        = s.rdata;
    assign aux_pin_o      = s.aux_pins;
    assign aux_serial_rx_o = s.aux_rx;
endmodule

// ### verilog/hub_defines.svh
// constants of the host-transport uart and its baud generator
`ifndef HUB_DEFINES_SVH
`define HUB_DEFINES_SVH
`define HUB_ADDR_DIV      3'h0
`define HUB_ADDR_STUFF    3'h1
`define HUB_ADDR_CTRL     3'h2
`define HUB_ADDR_STATUS   3'h3
`define HUB_ADDR_DATA     3'h4
`define HUB_CTRL_BOOT     0
`define HUB_CTRL_ROUTE_LO 1
`define HUB_ST_TX_EMPTY   0
`define HUB_ST_RX_AVAIL   1
`define HUB_ST_TX_FULL    2
`define HUB_ST_OVERRUN    3
`define HUB_ST_FRAME_ERR  4
`define HUB_DIV_RESET     8'hF3
`define HUB_STUFF_RESET   8'h00
`define HUB_DIV_BASE      9'h100
`define HUB_BOOT_MIN_DIV  9'h002
`define HUB_STUFF_MAX     4'h8
`define HUB_LAST_BIT      4'h9
`define HUB_QUEUE_DEPTH   1040
`define HUB_RTS_MARGIN    4
`define HUB_HOST_BIT_CYC  208
`endif

// ### verilog/hub_pkg.sv
// types shared by both ends of the host-transport uart
package hub_pkg;
    typedef enum logic {HUB_IDLE, HUB_BUSY} hub_ser_st_t;

    // one serial shifter: bit index 0 start, 1..8 data, 9 stop
    typedef struct packed {
        hub_ser_st_t st;
        logic [3:0]  idx;
        logic [11:0] cnt;
        logic        ph;
        logic [7:0]  sh;
    } hub_ser_t;

    typedef struct packed {
        logic [7:0] div;
        logic [7:0] stuff;
        logic       boot;
        logic [1:0] route;
        logic       ovr;
        logic       ferr;
        logic [7:0] rdata;
        hub_ser_t   tx;
        hub_ser_t   rx;
        logic       tx_line;
        logic       rts_n;
        logic [1:0] cts_s;
        logic [1:0] rx_s;
        logic [1:0][3:0] aux_s;
        logic [3:0] aux_pins;
        logic       aux_rx;
    } hub_dev_t;

    typedef struct packed {
        hub_ser_t   tx;
        hub_ser_t   rx;
        logic       tx_line;
        logic       rts_n;
        logic       tx_ready;
        logic       rx_valid;
        logic [7:0] rx_data;
        logic [1:0] cts_s;
        logic [1:0] rx_s;
    } hub_host_t;
endpackage

// ### verilog/hub_link_if.sv
// four-wire serial link between the device and the host
`timescale 1ns/1ns
interface hub_link_if;
    logic dev_tx;
    logic dev_rts_n;
    logic host_tx;
    logic host_rts_n;
    modport dev  (output dev_tx, output dev_rts_n, input host_tx, input host_rts_n);
    modport host (input dev_tx, input dev_rts_n, output host_tx, output host_rts_n);
endinterface

// ### verilog/hub_fifo.sv
// first-in first-out byte queue with valid/ready on both sides
`timescale 1ns/1ns
module hub_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [W-1:0]           in_data_i,
    input  wire logic                   in_valid_i,
    output logic                        in_ready_o,
    output logic [W-1:0]                out_data_o,
    output logic                        out_valid_o,
    input  wire logic                   out_ready_i,
    output logic [$clog2(D+1)-1:0]      count_o
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);
    localparam logic [AW-1:0] LAST = AW'(D - 1);
    localparam logic [CW-1:0] FULL = CW'(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } hub_fifo_st_t;

    if (D < 2 || W < 1) begin : g_chk
        $error("hub_fifo: depth must be at least 2");
    end

    logic [W-1:0] mem [D];
    hub_fifo_st_t s;
    hub_fifo_st_t n;
    logic         push;
    logic         pop;

    assign in_ready_o  = (s.cnt != FULL);
    assign out_valid_o = (s.cnt != '0);
    assign out_data_o  = mem[s.rp];
    assign count_o     = s.cnt;

    // pointers wrap by hand since the depth need not be a power of two
    always_comb begin
        n    = s;
        push = in_valid_i && in_ready_o;
        pop  = out_valid_o && out_ready_i;
        if (push) begin
            n.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
        end
        n.cnt = s.cnt + CW'(push) - CW'(pop);
    end

    // storage carries no reset so it can map onto ram
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[s.wp] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule

// ### verilog/hub_host.sv
// host end: fixed-rate 8N1 uart with rts/cts flow control
`timescale 1ns/1ns
`include "hub_defines.svh"
module hub_host
    import hub_pkg::*;
#(
    parameter int BIT_CYC = `HUB_HOST_BIT_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    hub_link_if.host        link,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i
);
    localparam logic [11:0] BIT_LAST  = 12'(BIT_CYC - 1);
    localparam logic [11:0] HALF_LAST = 12'(BIT_CYC / 2 - 1);

    if (BIT_CYC < 4 || BIT_CYC > 4095) begin : g_chk
        $error("hub_host: bit time out of range");
    end

    localparam hub_host_t HOST_RST = '{
        tx:       '{HUB_IDLE, 4'h0, 12'h000, 1'b0, 8'h00},
        rx:       '{HUB_IDLE, 4'h0, 12'h000, 1'b0, 8'h00},
        tx_line:  1'b1,
        rts_n:    1'b1,
        tx_ready: 1'b0,
        rx_valid: 1'b0,
        rx_data:  8'h00,
        cts_s:    2'b11,
        rx_s:     2'b11
    };

    hub_host_t s;
    hub_host_t n;
    logic      rx_line;

    // next-state of the host
    always_comb begin
        n          = s;
        rx_line    = s.rx_s[1];
        n.cts_s    = {s.cts_s[0], link.dev_rts_n};
        n.rx_s     = {s.rx_s[0], link.dev_tx};
        n.rx_valid = 1'b0;
        n.rts_n    = !rx_ready_i;

        // transmit: one character per accepted request
        case (s.tx.st)
            HUB_IDLE: begin
                n.tx_line  = 1'b1;
                n.tx_ready = !s.cts_s[1];
                if (tx_valid_i && s.tx_ready) begin
                    n.tx       = '{HUB_BUSY, 4'h0, 12'h000, 1'b0, tx_data_i};
                    n.tx_line  = 1'b0;
                    n.tx_ready = 1'b0;
                end
            end
            HUB_BUSY: begin
                if (s.tx.cnt == BIT_LAST) begin
                    n.tx.cnt = 12'h000;
                    if (s.tx.idx == `HUB_LAST_BIT) begin
                        n.tx.st = HUB_IDLE;
                    end else begin
                        n.tx.idx = s.tx.idx + 4'h1;
                        if (s.tx.idx == 4'h0) begin
                            n.tx_line = s.tx.sh[0];
                        end else begin
                            n.tx.sh   = {1'b0, s.tx.sh[7:1]};
                            n.tx_line = (s.tx.idx == 4'h8) ? 1'b1 : s.tx.sh[1];
                        end
                    end
                end else begin
                    n.tx.cnt = s.tx.cnt + 12'h001;
                end
            end
            default: n.tx.st = HUB_IDLE;
        endcase

        // receive: first sample half a bit in, then once per bit
        case (s.rx.st)
            HUB_IDLE: begin
                if (!rx_line) begin
                    n.rx = '{HUB_BUSY, 4'h0, 12'h000, 1'b0, s.rx.sh};
                end
            end
            HUB_BUSY: begin
                if (s.rx.cnt == ((s.rx.idx == 4'h0) ? HALF_LAST : BIT_LAST)) begin
                    n.rx.cnt = 12'h000;
                    n.rx.idx = s.rx.idx + 4'h1;
                    if (s.rx.idx == 4'h0) begin
                        if (rx_line) begin
                            n.rx.st = HUB_IDLE;
                        end
                    end else if (s.rx.idx != `HUB_LAST_BIT) begin
                        n.rx.sh = {rx_line, s.rx.sh[7:1]};
                    end else begin
                        n.rx.st = HUB_IDLE;
                        if (rx_line) begin
                            n.rx_valid = 1'b1;
                            n.rx_data  = s.rx.sh;
                        end
                    end
                end else begin
                    n.rx.cnt = s.rx.cnt + 12'h001;
                end
            end
            default: n.rx.st = HUB_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= HOST_RST;
        end else begin
            s <= n;
        end
    end

    assign link.host_tx    = s.tx_line;
    assign link.host_rts_n = s.rts_n;
    assign tx_ready_o      = s.tx_ready;
    assign rx_data_o       = s.rx_data;
    assign rx_valid_o      = s.rx_valid;
endmodule

// ### tb/hub_link_monitor.sv
// link checker for the four-wire host-transport uart
`timescale 1ns/1ns
module hub_link_monitor (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic dev_tx,
    input  wire logic dev_rts_n,
    input  wire logic host_tx,
    input  wire logic host_rts_n
);
    // start plus eight zero bits at the slowest rate the bench uses
    localparam int MAX_LOW = 1872;
    logic [11:0] dev_low;
    logic [11:0] host_low;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // low-run counters; a lost stop bit makes them overrun
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_low  <= 12'h000;
            host_low <= 12'h000;
        end else begin
            dev_low  <= dev_tx ? 12'h000 : dev_low + 12'h001;
            host_low <= host_tx ? 12'h000 : host_low + 12'h001;
        end
    end
    property p_idle_rst; $rose(rst_n_i) |-> dev_tx && host_tx && !dev_rts_n; endproperty
    a_idle_rst: assert property (p_idle_rst) else $error("link not idle after reset");
    property p_dev_low; dev_low <= 12'(MAX_LOW); endproperty
    a_dev_low: assert property (p_dev_low) else $error("device line low too long");
    property p_host_low; host_low <= 12'(MAX_LOW); endproperty
    a_host_low: assert property (p_host_low) else $error("host line low too long");
    // host runs at the default rate, so every low run is whole bits
    property p_host_bits; $rose(host_tx) |-> (host_low % 12'h0D0) == 12'h000; endproperty
    a_host_bits: assert property (p_host_bits) else $error("host low run not whole bits");
    property p_host_start; $fell(host_tx) |-> ##207 !host_tx; endproperty
    a_host_start: assert property (p_host_start) else $error("host start bit short");
    // boot cap keeps the divisor at two or more: 32 cycles per bit at least
    property p_dev_start; $fell(dev_tx) |-> !dev_tx [*8] ##24 !dev_tx; endproperty
    a_dev_start: assert property (p_dev_start) else $error("device start bit short");
    property p_cts_dev; host_rts_n [*4] |-> ##1 !$fell(dev_tx); endproperty
    a_cts_dev: assert property (p_cts_dev) else $error("device sent while host not ready");
    property p_cts_host; dev_rts_n [*4] |-> ##1 !$fell(host_tx); endproperty
    a_cts_host: assert property (p_cts_host) else $error("host sent while device not ready");
endmodule

// ### tb/hub_test.sv
// self-checking bench: register port, rate table, both directions, flow control
`timescale 1ns/1ns
`include "hub_defines.svh"
module hub_test;
    logic       clk_i, rst_n_i, wr_i, rd_i, tx_valid_i, rx_ready_i, tx_ready_o, rx_valid_o;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o, tx_data_i, rx_data_o, rd_v;
    logic       aux_serial_tx_i, aux_serial_rx_o;
    logic [3:0] aux_pin_o, aux_pin_i;
    logic [7:0] rx_q[$];
    logic [7:0] div_tab[4] = '{8'hFE, 8'hFD, 8'hFF, 8'hF3};
    logic [7:0] stf_tab[4] = '{8'h9A, 8'h22, 8'h00, 8'h00};
    int         mismatches = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         n;
    hub_link_if hub_link_if_inst ();
    hub_device #(.DEPTH(16)) hub_device_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(hub_link_if_inst.dev),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .aux_serial_tx_i(aux_serial_tx_i), .aux_serial_rx_o(aux_serial_rx_o), .aux_pin_i(aux_pin_i),
        .aux_pin_o(aux_pin_o));
    hub_host hub_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(hub_link_if_inst.host),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i));
    hub_link_monitor hub_link_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .dev_tx(hub_link_if_inst.dev_tx),
        .dev_rts_n(hub_link_if_inst.dev_rts_n), .host_tx(hub_link_if_inst.host_tx),
        .host_rts_n(hub_link_if_inst.host_rts_n));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // capture host deliveries; a hang ends the run as a failure
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
        if (cyc == 90000) begin
            mismatches++;
            final_report();
        end
    end
    // bit length from divisor and saturated stuffing nibbles, boot cap on
    function automatic int bit_len(input logic [7:0] dv, input logic [7:0] st);
        int d;
        d = 256 - int'(dv);
        if (d < 2) d = 2;
        return 16 * d + (st[7:4] > 8 ? 8 : st[7:4]) + (st[3:0] > 8 ? 8 : st[3:0]);
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        rd_v = rdata_o;
        chk(what, {8'h00, exp}, {8'h00, rd_v});
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge clk_i);
        tx_data_i <= b;
        tx_valid_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (tx_ready_o !== 1'b1 && n < 5000);
        tx_valid_i <= 1'b0;
        if (n >= 5000) mismatches++;
    endtask
    task automatic wait_rx(input int k);
        n = 0;
        while (rx_q.size() < k && n < 6000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 6000) mismatches++;
    endtask
    // a zero byte gives one low run of start plus eight data bits
    task automatic meas();
        n = 0;
        while (hub_link_if_inst.dev_tx !== 1'b0 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        while (hub_link_if_inst.dev_tx !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 4000) mismatches++;
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {rst_n_i, wr_i, rd_i, tx_valid_i, addr_i, wdata_i, tx_data_i} = '0;
        rx_ready_i = 1'b1;
        aux_serial_tx_i = 1'b1;
        aux_pin_i = 4'hF;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // reset values, unmapped index, pads idle
        rd_chk("div", `HUB_ADDR_DIV, 8'hF3);
        rd_chk("stuff", `HUB_ADDR_STUFF, 8'h00);
        rd_chk("ctrl", `HUB_ADDR_CTRL, 8'h01);
        rd_chk("status", `HUB_ADDR_STATUS, 8'h01);
        rd_chk("unmapped", 3'h7, 8'h00);
        chk("aux pads", 16'h000F, {12'h000, aux_pin_o});
        // peripheral port routed to pad two, both directions
        wr(`HUB_ADDR_CTRL, 8'h05);
        rd_chk("ctrl route", `HUB_ADDR_CTRL, 8'h05);
        aux_serial_tx_i <= 1'b0;
        aux_pin_i <= 4'hB;
        repeat (4) @(posedge clk_i);
        chk("aux tx pad", 16'h000B, {12'h000, aux_pin_o});
        chk("aux rx pad", 16'h0000, {15'h0, aux_serial_rx_o});
        // rate table, ending back at the default rate
        foreach (div_tab[i]) begin
            wr(`HUB_ADDR_DIV, div_tab[i]);
            wr(`HUB_ADDR_STUFF, stf_tab[i]);
            rd_chk("div raw", `HUB_ADDR_DIV, div_tab[i]);
            rd_chk("stuff raw", `HUB_ADDR_STUFF, stf_tab[i]);
            wr(`HUB_ADDR_DATA, 8'h00);
            meas();
            chk("low run", 16'(9 * bit_len(div_tab[i], stf_tab[i])), 16'(n));
            repeat (2500) @(posedge clk_i);
        end
        // host holds off: queue fills, seventeenth byte dropped, then drained fast
        rx_ready_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 17; i++) wr(`HUB_ADDR_DATA, 8'h00);
        rd_chk("status full", `HUB_ADDR_STATUS, 8'h04);
        wr(`HUB_ADDR_DIV, 8'hFF);
        rx_ready_i <= 1'b1;
        repeat (8000) @(posedge clk_i);
        rd_chk("status drained", `HUB_ADDR_STATUS, 8'h01);
        wr(`HUB_ADDR_DIV, 8'hF3);
        // device to host held back while host is not ready
        rx_q.delete();
        rx_ready_i <= 1'b0;
        // the stop must cross the host flop and the device synchroniser first
        repeat (4) @(posedge clk_i);
        wr(`HUB_ADDR_DATA, 8'h55);
        wr(`HUB_ADDR_DATA, 8'hA6);
        repeat (600) @(posedge clk_i);
        chk("tx held", 16'h0001, {15'h0, hub_link_if_inst.dev_tx});
        rx_ready_i <= 1'b1;
        wait_rx(2);
        chk("rx byte 0", 16'h0055, {8'h00, rx_q[0]});
        chk("rx byte 1", 16'h00A6, {8'h00, rx_q[1]});
        // host to device until the receive queue nears full
        for (int i = 0; i < 12; i++) send(8'(i * 17 + 3));
        repeat (2300) @(posedge clk_i);
        chk("rts near full", 16'h0001, {15'h0, hub_link_if_inst.dev_rts_n});
        // host request stays pending until the device frees room
        tx_data_i <= 8'hC4;
        tx_valid_i <= 1'b1;
        repeat (300) @(posedge clk_i);
        chk("host held", 16'h0001, {15'h0, hub_link_if_inst.host_tx});
        rd_chk("status rx", `HUB_ADDR_STATUS, 8'h03);
        for (int i = 0; i < 12; i++) rd_chk("rx data", `HUB_ADDR_DATA, 8'(i * 17 + 3));
        chk("rts ready", 16'h0000, {15'h0, hub_link_if_inst.dev_rts_n});
        tx_valid_i <= 1'b0;
        repeat (2300) @(posedge clk_i);
        rd_chk("held byte", `HUB_ADDR_DATA, 8'hC4);
        final_report();
    end
endmodule
